/* hw/isp_map.svh */
// Constants for the serial-bus register port: addresses, widths and timing.
`ifndef ISP_MAP_SVH
`define ISP_MAP_SVH

`define ISP_ADDR_LOW        7'h18
`define ISP_ADDR_HIGH       7'h19
`define ISP_RW_READ         1'h1
`define ISP_PTR_RESET       8'h00
`define ISP_BITS_PER_BYTE   4'h8
`define ISP_WDT_W           23
`define ISP_CLK_PERIOD_NS   10
`define ISP_WDT_SHORT_US    1000
`define ISP_WDT_LONG_US     50000
`define ISP_WDT_SHORT_CYC   (`ISP_WDT_SHORT_US * 1000 / `ISP_CLK_PERIOD_NS)
`define ISP_WDT_LONG_CYC    (`ISP_WDT_LONG_US * 1000 / `ISP_CLK_PERIOD_NS)

`endif

/* hw/isp_pkg.sv */
// Types shared by the serial-bus register port modules.
`default_nettype none
`include "isp_map.svh"

package isp_pkg;

  typedef enum logic [2:0] {
    ISP_IDLE,
    ISP_RX,
    ISP_ACK,
    ISP_TX,
    ISP_TXACK,
    ISP_IGNORE
  } isp_state_e;

  typedef enum logic [1:0] {
    ISP_PH_ADDR,
    ISP_PH_REG,
    ISP_PH_DATA
  } isp_phase_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic asel;
  } isp_pins_s;

  typedef struct packed {
    isp_pins_s meta;
    isp_pins_s stable;
  } isp_sync_s;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } isp_wr_s;

  typedef struct packed {
    isp_state_e             state;
    isp_phase_e             phase;
    logic                   scl_q;
    logic                   sda_q;
    logic                   low_seen;
    logic [3:0]             cnt;
    logic [7:0]             sh;
    logic                   to_tx;
    logic                   nack;
    logic [7:0]             base;
    logic [7:0]             ptr;
    isp_wr_s                wr;
    logic                   sda_oe;
    logic                   sda_out;
    logic                   busy;
    logic [`ISP_WDT_W-1:0]  wdt;
    logic                   wdt_fire;
  } isp_regs_s;

endpackage : isp_pkg

`default_nettype wire

/* hw/isp_sync.sv */
// Two-stage synchroniser for the clock, data and strap pins.
`default_nettype none

module isp_sync
  import isp_pkg::*;
(
  input  wire logic            ref_clk_i,
  input  wire logic            reset_i,
  input  wire logic            ce_i,
  input  wire isp_pkg::isp_pins_s pins_i,
  output var  isp_pkg::isp_pins_s pins_o
);
  import isp_pkg::*;

  isp_sync_s q_ff;
  isp_sync_s nxt_q;

  // The first stage feeds only the second one.
  always_comb
  begin
    nxt_q.meta   = pins_i;
    nxt_q.stable = q_ff.meta;
  end

  // Idle bus lines are pulled high, so reset to the released level.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      q_ff <= '{meta: '{scl: 1'b1, sda: 1'b1, asel: 1'b0},
                stable: '{scl: 1'b1, sda: 1'b1, asel: 1'b0}};
    end
    else if (ce_i)
    begin
      q_ff <= nxt_q;
    end
  end

  assign pins_o = q_ff.stable;

endmodule : isp_sync

`default_nettype wire

/* hw/isp_target.sv */
// Serial-bus target port giving a bus master access to the register space.
`default_nettype none
`include "isp_map.svh"

// Contract
// - Act as standard/fast-mode target with 7-bit addressing only; no 10-bit.
// - Answer address 0x18 with strap low, 0x19 with strap high.
// - SDA falling while SCL high is a start; bus busy from then.
// - SDA rising while SCL high is a stop and ends the transfer; the port ignores one that comes before SCL has gone low after a start.
// - Receiver holds SDA low through the ninth clock; transmitter releases.
// - Write: address, RW 0, ack, register address, ack, data, ack, stop.
// - Store the one received data byte at the received register address.
// - Read: write phase with address, repeated start, address with RW 1.
// - Master target_acknowledge to get more; a nack makes the device release SDA.
// - Register pointer advances by one after each byte read.
// - Each read starts at the latest written address, 0x00 before any.
// - Watchdog resets the port when the device holds the bus locked.
// - Watchdog is on when its enable bit is one, off when zero.
// - Period select low gives 1 ms, high gives 50 ms.
module isp_target
  import isp_pkg::*;
#(
  parameter int unsigned WDT_SHORT_CYC = `ISP_WDT_SHORT_CYC,
  parameter int unsigned WDT_LONG_CYC  = `ISP_WDT_LONG_CYC
)
(
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  input  wire logic             serial_clock_pin_i,
  input  wire logic             serial_data_pin_i,
  output var  logic             serial_data_pin_o,
  output var  logic             serial_data_pin_oe_o,
  input  wire logic             address_select_pin_i,
  input  wire logic             wdt_en_i,
  input  wire logic             wdt_sel_i,
  input  wire logic [7:0]       rd_data_i,
  output var  logic [7:0]       rd_addr_o,
  output var  isp_pkg::isp_wr_s wr_o,
  output var  logic             busy_o,
  output var  logic             wdt_reset_o
);
  import isp_pkg::*;

  isp_pins_s pins_in;
  isp_pins_s pins;
  isp_regs_s q_ff;
  isp_regs_s nxt_q;

  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [6:0] own_addr;
  logic [`ISP_WDT_W-1:0] wdt_limit;

  // Watchdog limit in cycles for the selected period.
  function automatic logic [`ISP_WDT_W-1:0] wdt_cycles(input logic sel);
    if (sel)
      return WDT_LONG_CYC[`ISP_WDT_W-1:0];
    else
      return WDT_SHORT_CYC[`ISP_WDT_W-1:0];
  endfunction : wdt_cycles

  assign pins_in = '{scl: serial_clock_pin_i,
                     sda: serial_data_pin_i,
                     asel: address_select_pin_i};

  isp_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .pins_i    (pins_in),
    .pins_o    (pins)
  );

  assign rise  = pins.scl & ~q_ff.scl_q;
  assign fall  = ~pins.scl & q_ff.scl_q;
  assign start = q_ff.scl_q & pins.scl & q_ff.sda_q & ~pins.sda;
  assign stop  = q_ff.scl_q & pins.scl & ~q_ff.sda_q & pins.sda;
  assign own_addr = pins.asel ? `ISP_ADDR_HIGH : `ISP_ADDR_LOW;
  assign wdt_limit = wdt_cycles(wdt_sel_i);

  always_comb
  begin
    nxt_q          = q_ff;
    nxt_q.scl_q    = pins.scl;
    nxt_q.sda_q    = pins.sda;
    nxt_q.wr.en    = 1'b0;
    nxt_q.wdt_fire = 1'b0;
    nxt_q.sda_out  = 1'b0;

    if (fall)
    begin
      nxt_q.low_seen = 1'b1;
    end

    unique case (q_ff.state)
      ISP_IDLE, ISP_IGNORE:
      begin
        nxt_q.sda_oe = 1'b0;
      end
      ISP_RX:
      begin
        if (rise)
        begin
          nxt_q.sh  = {q_ff.sh[6:0], pins.sda};
          nxt_q.cnt = q_ff.cnt + 4'h1;
        end
        else if (fall && q_ff.cnt == `ISP_BITS_PER_BYTE)
        begin
          nxt_q.cnt = 4'h0;
          unique case (q_ff.phase)
            ISP_PH_ADDR:
            begin
              // A 10-bit header never equals a 7-bit address.
              if (q_ff.sh[7:1] == own_addr)
              begin
                nxt_q.state  = ISP_ACK;
                nxt_q.sda_oe = 1'b1;
                nxt_q.to_tx  = (q_ff.sh[0] == `ISP_RW_READ);
                nxt_q.phase  = ISP_PH_REG;
                nxt_q.ptr    = q_ff.base;
              end
              else
              begin
                nxt_q.state = ISP_IGNORE;
              end
            end
            ISP_PH_REG:
            begin
              nxt_q.state  = ISP_ACK;
              nxt_q.sda_oe = 1'b1;
              nxt_q.base   = q_ff.sh;
              nxt_q.phase  = ISP_PH_DATA;
            end
            ISP_PH_DATA:
            begin
              nxt_q.state   = ISP_ACK;
              nxt_q.sda_oe  = 1'b1;
              nxt_q.wr.en   = 1'b1;
              nxt_q.wr.addr = q_ff.base;
              nxt_q.wr.data = q_ff.sh;
              // Only one data byte per write; later bytes are not acked.
              nxt_q.phase   = ISP_PH_ADDR;
            end
            default:
            begin
              nxt_q.state = ISP_IGNORE;
            end
          endcase
        end
      end
      ISP_ACK:
      begin
        if (fall)
        begin
          nxt_q.cnt = 4'h0;
          if (q_ff.to_tx)
          begin
            nxt_q.state  = ISP_TX;
            nxt_q.sh     = rd_data_i;
            nxt_q.sda_oe = ~rd_data_i[7];
          end
          else if (q_ff.phase == ISP_PH_ADDR)
          begin
            nxt_q.state  = ISP_IGNORE;
            nxt_q.sda_oe = 1'b0;
          end
          else
          begin
            nxt_q.state  = ISP_RX;
            nxt_q.sda_oe = 1'b0;
          end
        end
      end
      ISP_TX:
      begin
        if (rise)
        begin
          nxt_q.cnt = q_ff.cnt + 4'h1;
        end
        else if (fall)
        begin
          if (q_ff.cnt == `ISP_BITS_PER_BYTE)
          begin
            nxt_q.state  = ISP_TXACK;
            nxt_q.sda_oe = 1'b0;
          end
          else
          begin
            nxt_q.sh     = {q_ff.sh[6:0], 1'b0};
            nxt_q.sda_oe = ~q_ff.sh[6];
          end
        end
      end
      ISP_TXACK:
      begin
        if (rise)
        begin
          nxt_q.nack = pins.sda;
          nxt_q.ptr  = q_ff.ptr + 8'h01;
        end
        else if (fall)
        begin
          nxt_q.cnt = 4'h0;
          if (q_ff.nack)
          begin
            nxt_q.state = ISP_IGNORE;
          end
          else
          begin
            nxt_q.state  = ISP_TX;
            nxt_q.sh     = rd_data_i;
            nxt_q.sda_oe = ~rd_data_i[7];
          end
        end
      end
      default:
      begin
        nxt_q.state  = ISP_IDLE;
        nxt_q.sda_oe = 1'b0;
      end
    endcase

    // The count only runs while this port pulls SDA low, so a slow
    // master that stretches SCL with the line released never trips it.
    if (wdt_en_i && q_ff.sda_oe && !rise && !fall)
    begin
      nxt_q.wdt = q_ff.wdt + 1'b1;
    end
    else
    begin
      nxt_q.wdt = '0;
    end
    if (wdt_en_i && q_ff.sda_oe && q_ff.wdt >= wdt_limit)
    begin
      nxt_q.state    = ISP_IDLE;
      nxt_q.sda_oe   = 1'b0;
      nxt_q.busy     = 1'b0;
      nxt_q.wdt      = '0;
      nxt_q.wdt_fire = 1'b1;
    end

    if (start)
    begin
      nxt_q.state    = ISP_RX;
      nxt_q.phase    = ISP_PH_ADDR;
      nxt_q.cnt      = 4'h0;
      nxt_q.sda_oe   = 1'b0;
      nxt_q.busy     = 1'b1;
      nxt_q.low_seen = 1'b0;
      nxt_q.to_tx    = 1'b0;
    end
    else if (stop && q_ff.low_seen)
    begin
      nxt_q.state  = ISP_IDLE;
      nxt_q.sda_oe = 1'b0;
      nxt_q.busy   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      q_ff       <= '0;
      q_ff.state <= ISP_IDLE;
      q_ff.phase <= ISP_PH_ADDR;
      q_ff.scl_q <= 1'b1;
      q_ff.sda_q <= 1'b1;
      q_ff.base  <= `ISP_PTR_RESET;
      q_ff.ptr   <= `ISP_PTR_RESET;
    end
    else if (ce_i)
    begin
      q_ff <= nxt_q;
    end
  end

  assign serial_data_pin_o    = q_ff.sda_out;
  assign serial_data_pin_oe_o = q_ff.sda_oe;
  assign rd_addr_o            = q_ff.ptr;
  assign wr_o                 = q_ff.wr;
  assign busy_o               = q_ff.busy;
  assign wdt_reset_o          = q_ff.wdt_fire;

endmodule : isp_target

`default_nettype wire

/* tb/isp_target_asserts.sv */
// Concurrent checks on the serial-bus target port, bound to its ports.
`default_nettype none

module isp_target_asserts
  import isp_pkg::*;
#(
  parameter int unsigned WDT_SHORT_CYC = 50,
  parameter int unsigned WDT_LONG_CYC  = 200
)
(
  input wire logic              ref_clk_i,
  input wire logic              reset_i,
  input wire logic              serial_clock_pin_i,
  input wire logic              serial_data_pin_i,
  input wire logic              serial_data_pin_o,
  input wire logic              serial_data_pin_oe_o,
  input wire logic              wdt_en_i,
  input wire logic              wdt_sel_i,
  input wire logic [7:0]        rd_addr_o,
  input wire isp_pkg::isp_wr_s  wr_o,
  input wire logic              busy_o,
  input wire logic              wdt_reset_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  wire logic        scl = serial_clock_pin_i;
  wire logic        sda = serial_data_pin_i;
  wire logic        oe  = serial_data_pin_oe_o;
  wire logic [31:0] lim = wdt_sel_i ? WDT_LONG_CYC : WDT_SHORT_CYC;
  logic             sl_ff;
  logic [23:0]      stl_ff;
  // A stop only counts once SCL has been low since the last start.
  always_ff @(posedge ref_clk_i)
    if (reset_i || ($fell(sda) && scl))
      sl_ff <= 1'h0;
    else if (!scl)
      sl_ff <= 1'h1;
  // Cycles spent holding SDA low since SCL last moved.
  always_ff @(posedge ref_clk_i)
    if (reset_i || $changed(scl) || !wdt_en_i)
      stl_ff <= 24'h00_0000;
    else
      stl_ff <= stl_ff + 24'(oe);

  AST_OPEN_DRAIN: assert property (oe |-> !serial_data_pin_o)
    else $error("data pin driven high");
  AST_START_BUSY: assert property ($fell(sda) && scl && $past(scl)
    |-> ##[1:6] busy_o) else $error("start did not set busy");
  AST_STOP_IDLE: assert property ($rose(sda) && scl && sl_ff
    |-> ##[1:6] !busy_o) else $error("stop did not clear busy");
  AST_STOP_IGNORED: assert property ($rose(sda) && scl && !sl_ff
    |-> ##6 busy_o) else $error("stop right after start was taken");
  AST_WR_PULSE: assert property (wr_o.en |=> !wr_o.en && oe)
    else $error("write strobe too long or not acknowledged");
  AST_ACK_HOLD: assert property (scl && $past(scl)
    |-> $stable(oe)) else $error("data drive moved while clock high");
  AST_WDT_TIME: assert property (wdt_reset_o
    |-> stl_ff + 5 >= lim && stl_ff <= lim + 5) else $error("bad period");
  AST_WDT_OFF: assert property (!wdt_en_i |-> !wdt_reset_o)
    else $error("watchdog fired while disabled");
  AST_RESET_STATE: assert property ($past(reset_i)
    |-> !busy_o && !oe && rd_addr_o == 8'h00) else $error("bad reset state");
  cover property (wr_o.en);
  cover property (wdt_reset_o);
  cover property ($rose(busy_o));
endmodule : isp_target_asserts

bind isp_target isp_target_asserts #(
  .WDT_SHORT_CYC (WDT_SHORT_CYC),
  .WDT_LONG_CYC  (WDT_LONG_CYC)
) u_chk (
  .ref_clk_i            (ref_clk_i),
  .reset_i              (reset_i),
  .serial_clock_pin_i   (serial_clock_pin_i),
  .serial_data_pin_i    (serial_data_pin_i),
  .serial_data_pin_o    (serial_data_pin_o),
  .serial_data_pin_oe_o (serial_data_pin_oe_o),
  .wdt_en_i             (wdt_en_i),
  .wdt_sel_i            (wdt_sel_i),
  .rd_addr_o            (rd_addr_o),
  .wr_o                 (wr_o),
  .busy_o               (busy_o),
  .wdt_reset_o          (wdt_reset_o)
);

`default_nettype wire

/* tb/isp_host_model.sv */
// Bus master model: drives the serial clock and pulls the data line low.
`default_nettype none

module isp_host_model
(
  output var  logic scl_o,
  output var  logic sda_oe_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {scl_o, sda_oe_o} = 2'h2;
  // SCL rises 50 ns into the bit so a target still holding its
  // acknowledge has let go first; otherwise a stop would appear.
  task automatic xbit(input logic b, output logic r);
    #20 sda_oe_o = !b;
    #30 scl_o = 1'h1;
    #20 r = sda_i;
    #10 scl_o = 1'h0;
  endtask : xbit
  task automatic start();
    #20 sda_oe_o = 1'h0;
    #30 scl_o = 1'h1;
    #20 sda_oe_o = 1'h1;
    #10 scl_o = 1'h0;
  endtask : start
  // Stop, then the idle gap that a write needs in normal mode.
  task automatic stop();
    #20 sda_oe_o = 1'h1;
    #30 scl_o = 1'h1;
    #20 sda_oe_o = 1'h0;
    #2000;
  endtask : stop
  // Stop with the far longer idle gap that suspend or low-power-1 needs.
  task automatic stop_long();
    stop();
    #448000;
  endtask : stop_long
  // Start at once followed by stop, SCL never low; only on command.
  task automatic glitch();
    #20 sda_oe_o = 1'h1;
    #20 sda_oe_o = 1'h0;
    #20;
  endtask : glitch
  task automatic send8(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
  endtask : send8
  task automatic wbyte(input logic [7:0] d, output logic a);
    send8(d);
    xbit(1'h1, a);
  endtask : wbyte
  task automatic rbyte(input logic m, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(1'h1, d[i]);
    xbit(m, r);
  endtask : rbyte
endmodule : isp_host_model

`default_nettype wire

/* tb/test_isp_target.sv */
// Self-checking bench for the serial-bus target port.
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module test_isp_target;
  timeunit 1ns;
  timeprecision 1ns;
  import isp_pkg::*;
  localparam int WS = 50;
  localparam int WL = 200;
  logic       clk = 1'h0, rst = 1'h1, asel = 1'h0, wen = 1'h0, wsel = 1'h0;
  logic       scl, moe, sda, doe, dout, busy, wrst, a, r;
  logic [7:0] raddr, rdat, d;
  isp_wr_s    wr;
  int         checks = 0, n_fail = 0, nwr = 0, n;
  // Open-drain line with a pull-up: low while either party pulls.
  assign sda  = !(moe || (doe && !dout));
  assign rdat = raddr + 8'h40;
  initial forever #5 clk = !clk;
  always @(posedge clk)
    if (wr.en === 1'h1)
      nwr <= nwr + 1;
  isp_host_model m (.scl_o(scl), .sda_oe_o(moe), .sda_i(sda));
  isp_target #(.WDT_SHORT_CYC(WS), .WDT_LONG_CYC(WL)) uut (
    .ref_clk_i(clk), .reset_i(rst), .ce_i(1'h1),
    .serial_clock_pin_i(scl), .serial_data_pin_i(sda),
    .serial_data_pin_o(dout), .serial_data_pin_oe_o(doe),
    .address_select_pin_i(asel), .wdt_en_i(wen), .wdt_sel_i(wsel),
    .rd_data_i(rdat), .rd_addr_o(raddr), .wr_o(wr), .busy_o(busy),
    .wdt_reset_o(wrst));

  task automatic addr(input logic [6:0] a7, input logic rw, input logic e);
    m.start();
    m.wbyte({a7, rw}, a);
    `CHK(a, e)
  endtask : addr
  task automatic t_rd0();
    addr(7'h18, 1'h1, 1'h0);
    m.rbyte(1'h0, d);
    `CHK(d, 8'h40)
    m.rbyte(1'h1, d);
    `CHK(d, 8'h41)
    m.xbit(1'h1, r);
    `CHK(r, 1'h1)
    m.stop();
    $display("rd0 done");
  endtask : t_rd0
  task automatic t_write();
    addr(7'h18, 1'h0, 1'h0);
    `CHK(busy, 1'h1)
    m.wbyte(8'h10, a);
    `CHK(a, 1'h0)
    m.wbyte(8'h09, a);
    `CHK({a, wr.addr, wr.data}, 17'h0_1009)
    m.wbyte(8'h77, a);
    `CHK(a, 1'h1)
    m.stop_long();
    `CHK(busy, 1'h0)
    `CHK(nwr, 1)
    $display("write done");
  endtask : t_write
  task automatic t_read();
    addr(7'h18, 1'h0, 1'h0);
    m.wbyte(8'h02, a);
    addr(7'h18, 1'h1, 1'h0);
    for (int i = 0; i < 3; i++)
    begin
      m.rbyte(i == 2, d);
      `CHK(d, 8'h42 + i[7:0])
    end
    m.stop();
    addr(7'h18, 1'h1, 1'h0);
    m.rbyte(1'h1, d);
    `CHK(d, 8'h42)
    m.stop();
    $display("read done");
  endtask : t_read
  task automatic t_strap();
    asel = 1'h1;
    repeat (4) @(negedge clk);
    addr(7'h18, 1'h0, 1'h1);
    m.wbyte(8'h10, a);
    m.wbyte(8'h55, a);
    `CHK(a, 1'h1)
    m.stop();
    `CHK(nwr, 1)
    addr(7'h78, 1'h0, 1'h1); // A ten-bit header is refused
    m.stop();
    addr(7'h19, 1'h0, 1'h0);
    m.stop();
    asel = 1'h0;
    $display("strap done");
  endtask : t_strap
  task automatic t_glitch();
    m.glitch();
    repeat (8) @(negedge clk);
    `CHK(busy, 1'h1)
    m.start();
    m.stop();
    `CHK(busy, 1'h0)
    $display("glitch done");
  endtask : t_glitch
  // The host stalls SCL low while the port acknowledges its address.
  task automatic t_wdt();
    int lim;
    for (int k = 0; k < 3; k++)
    begin
      wen  = (k < 2);
      wsel = (k == 1);
      lim  = (k == 0) ? WS : (k == 1) ? WL : 400;
      m.start();
      m.send8(8'h30);
      n = 0;
      while (wrst !== 1'h1 && n < 400)
      begin
        @(negedge clk);
        n++;
      end
      `CHK(n >= lim && n <= lim + 10, 1'h1)
      m.xbit(1'h1, a);
      `CHK(a, k < 2)
      m.stop();
    end
    $display("wdt done");
  endtask : t_wdt
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    // The suspend-mode idle gap alone takes 450 us of the run.
    #800000;
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'h0;
    repeat (5) @(negedge clk);
    t_rd0();
    t_write();
    t_read();
    t_strap();
    t_glitch();
    t_wdt();
    report_and_stop();
  end
endmodule : test_isp_target

`default_nettype wire
